/* hw/dual_clock_fifo_9bit.sv */
// Deep 9-bit FIFO with two reset kinds, reread, fall-through mode and APB status
//
// What this block does
// - Accept nine-bit write words
// - Full reset zeroes pointers and output
// - Full reset latches mode, default, method
// - Partial reset keeps mode, method, offsets
// - Reread returns read pointer to zero
// - Reread briefly forces empty or not-valid
// - Mode pin at reset, serial data after
// - Write stores word or parallel offset
// - Serial enable shifts one offset bit
// - Read delivers word or offset contents
// - Output enable registered onto readDataOeN
// - Access pin chooses 127 or 1,023 default
// - Access pin steers edges to offsets
// - Full flag or space-available by mode
// - Empty flag or output-valid by mode
// - Near-full low above capacity minus m
// - Near-empty low below offset n
// - Half mark shows above half capacity
// - Nine-bit data output bus
// - Low default parallel, high default serial
// - Fall-through first word after three edges
// - Depth is 65,536 words
`timescale 1ns/1ps
`default_nettype none
module dual_clock_fifo_9bit (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clkEn,
    // Write side
    input wire logic [dual_clock_fifo_9bit_pkg::DATA_W-1:0] writeDataIn,
    input wire logic writeEnN,
    input wire logic bitloadEnN,
    input wire logic modeSelSerialIn,
    // Control pins
    input wire logic offsetAccessN,
    input wire logic fullInitN,
    input wire logic softInitN,
    input wire logic rereadN,
    // Read side
    input wire logic readEnN,
    input wire logic outputEnableN,
    output logic [dual_clock_fifo_9bit_pkg::DATA_W-1:0] readDataOut,
    output logic readDataOeN,
    output var dual_clock_fifo_9bit_pkg::flags_s flags,
    // APB slave
    input wire dual_clock_fifo_9bit_pkg::apb_req_s apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import dual_clock_fifo_9bit_pkg::*;

    // ****************************************
    // State
    // ****************************************
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1]; // storage, no reset on purpose
    logic [PTR_W-1:0] wrPtr_q, wrPtr_d;       // Write pointer
    logic [PTR_W-1:0] rdPtr_q, rdPtr_d;       // Read pointer
    logic [PTR_W-1:0] wrStage_q [0:FALL_DELAY-1]; // Write pointer as seen by the read side
    logic [OFF_W-1:0] emptyOff_q, fullOff_q;  // Flag offsets n and m
    logic fwftMode_q;                          // Fall-through timing selected
    logic serialLoad_q;                        // Serial offset loading selected
    logic [1:0] wrStep_q, rdStep_q;            // Offset access sequence positions
    logic outValid_q;                          // Output register holds a word
    logic rereadHold_q;                        // Flag override after reread
    logic [DATA_W-1:0] dataOut_q;
    logic oeN_q;
    flags_s flags_q;
    logic wBlock_q, flush_q;                   // Software control bits
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;

    // ****************************************
    // Decode
    // ****************************************
    wire anyInit = !fullInitN || !softInitN || flush_q;
    wire [PTR_W-1:0] memCount = wrPtr_q - rdPtr_q;           // Words written, not yet read
    wire [PTR_W-1:0] seenCount = wrStage_q[FALL_DELAY-1] - rdPtr_q; // Read side view
    wire isFull = (memCount == DEPTH);
    wire seenEmpty = (seenCount == 17'h00000);
    // access pin steers edges to offsets
    wire wrOffset = !writeEnN && !offsetAccessN && !serialLoad_q;
    wire rdOffset = !readEnN && !offsetAccessN;
    wire wrMem = !writeEnN && offsetAccessN && !isFull && !wBlock_q;
    wire shiftBit = !bitloadEnN && !offsetAccessN && serialLoad_q;
    wire rdReq = !readEnN && offsetAccessN;
    // read only when a word is there
    wire stdPop = !fwftMode_q && rdReq && !seenEmpty;
    // fall-through refills an empty output register unasked
    wire fwftPop = fwftMode_q && !seenEmpty && (!outValid_q || rdReq);
    wire memPop = (stdPop || fwftPop) && rereadN;
    wire fwftDrain = fwftMode_q && rdReq && outValid_q && !memPop && rereadN;
    wire [31:0] offChain = {fullOff_q, emptyOff_q};
    wire [31:0] offShifted = {modeSelSerialIn, offChain[31:1]};
    wire [DATA_W-1:0] offWord = (rdStep_q == 2'h0) ? emptyOff_q[DATA_W-1:0] :
                                (rdStep_q == 2'h1) ? {2'h0, emptyOff_q[OFF_W-1:OFF_LO_W]} :
                                (rdStep_q == 2'h2) ? fullOff_q[DATA_W-1:0] :
                                {2'h0, fullOff_q[OFF_W-1:OFF_LO_W]};
    // APB decode
    wire apbSetup = apbReq.psel && !apbReq.penable;
    wire hitCtrl = (apbReq.paddr == ADDR_CTRL);
    wire hitStatus = (apbReq.paddr == ADDR_STATUS);
    wire hitCount = (apbReq.paddr == ADDR_COUNT);
    wire hitOffsets = (apbReq.paddr == ADDR_OFFSETS);
    wire hitAny = hitCtrl || hitStatus || hitCount || hitOffsets;
    wire apbWrite = apbReq.psel && apbReq.penable && pready_q && apbReq.pwrite && hitCtrl;

    // ****************************************
    // Pointer next values
    // ****************************************
    // both resets zero the pointers
    always_comb begin
        wrPtr_d = wrPtr_q;
        rdPtr_d = rdPtr_q;
        if (anyInit) begin
            wrPtr_d = '0;
            rdPtr_d = '0;
        end else begin
            if (wrMem) begin
                wrPtr_d = wrPtr_q + 17'h00001;
            end
            // reread resets only the read pointer
            if (!rereadN) begin
                rdPtr_d = '0;
            end else if (memPop) begin
                rdPtr_d = rdPtr_q + 17'h00001;
            end
        end
    end

    // ****************************************
    // Memory write
    // ****************************************
    // store the nine-bit word
    always_ff @(posedge clk_sys) begin
        if (clkEn && !anyInit && wrMem) begin
            mem[wrPtr_q[ADDR_W-1:0]] <= writeDataIn;
        end
    end

    // ****************************************
    // Pointers and write pointer staging
    // ****************************************
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else if (clkEn) begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
        end
    end

    // read side sees the write pointer late
    genvar gi;
    generate
        for (gi = 0; gi < FALL_DELAY; gi++) begin : gStage
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    wrStage_q[gi] <= '0;
                end else if (clkEn) begin
                    wrStage_q[gi] <= anyInit ? '0 : ((gi == 0) ? wrPtr_q : wrStage_q[(gi == 0) ? 0 : gi-1]);
                end
            end
        end
    endgenerate

    // ****************************************
    // Configuration latched at full reset
    // ****************************************
    // sample pins while full reset is low
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            fwftMode_q <= 1'b0;
            serialLoad_q <= 1'b0;
        end else if (clkEn && !fullInitN) begin
            fwftMode_q <= modeSelSerialIn;
            serialLoad_q <= offsetAccessN;
        end
    end

    // ****************************************
    // Offset registers
    // ****************************************
    // Partial reset leaves this process alone, so programmed values survive
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            emptyOff_q <= DEF_OFF_LOW;
            fullOff_q <= DEF_OFF_LOW;
            wrStep_q <= 2'h0;
        end else if (clkEn) begin
            if (!fullInitN) begin
                emptyOff_q <= offsetAccessN ? DEF_OFF_HIGH : DEF_OFF_LOW;
                fullOff_q <= offsetAccessN ? DEF_OFF_HIGH : DEF_OFF_LOW;
                wrStep_q <= 2'h0;
            end else if (shiftBit) begin
                {fullOff_q, emptyOff_q} <= offShifted;
            end else if (wrOffset) begin
                // parallel load, low part then high part
                case (wrStep_q)
                    2'h0: emptyOff_q[DATA_W-1:0] <= writeDataIn;
                    2'h1: emptyOff_q[OFF_W-1:OFF_LO_W] <= writeDataIn[OFF_W-OFF_LO_W-1:0];
                    2'h2: fullOff_q[DATA_W-1:0] <= writeDataIn;
                    default: fullOff_q[OFF_W-1:OFF_LO_W] <= writeDataIn[OFF_W-OFF_LO_W-1:0];
                endcase
                wrStep_q <= (wrStep_q == OFF_STEP_LAST) ? 2'h0 : wrStep_q + 2'h1;
            end
        end
    end

    // ****************************************
    // Output register
    // ****************************************
    // word or offset to the output bus
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dataOut_q <= '0;
            outValid_q <= 1'b0;
            rdStep_q <= 2'h0;
        end else if (clkEn) begin
            if (anyInit) begin
                dataOut_q <= '0;
                outValid_q <= 1'b0;
                rdStep_q <= fullInitN ? rdStep_q : 2'h0;
            end else if (rdOffset) begin
                dataOut_q <= offWord;
                rdStep_q <= (rdStep_q == OFF_STEP_LAST) ? 2'h0 : rdStep_q + 2'h1;
            end else if (!rereadN) begin
                // Reread drops the held word so the first one falls through again
                outValid_q <= 1'b0;
            end else if (memPop) begin
                dataOut_q <= mem[rdPtr_q[ADDR_W-1:0]];
                outValid_q <= 1'b1;
            end else if (fwftDrain) begin
                outValid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            oeN_q <= 1'b1;
        end else if (clkEn) begin
            oeN_q <= outputEnableN;
        end
    end

    // ****************************************
    // Flags
    // ****************************************
    // The reread override lasts while reread is low and one cycle after, long enough for the read side to notice
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rereadHold_q <= 1'b0;
        end else if (clkEn) begin
            rereadHold_q <= !rereadN && !anyInit;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            flags_q <= '{fullOrSpaceOut: 1'b1, emptyOrValidOut: 1'b0, nearFullN: 1'b1,
                         nearEmptyN: 1'b0, halfMarkN: 1'b1};
        end else if (clkEn) begin
            flags_q.fullOrSpaceOut <= fwftMode_q ? isFull : !isFull;
            if (!rereadN || rereadHold_q) begin
                flags_q.emptyOrValidOut <= fwftMode_q;
            end else begin
                flags_q.emptyOrValidOut <= fwftMode_q ? !outValid_q : !seenEmpty;
            end
            flags_q.nearFullN <= !(memCount > (DEPTH - {1'b0, fullOff_q}));
            flags_q.nearEmptyN <= !(memCount < {1'b0, emptyOff_q});
            flags_q.halfMarkN <= !(memCount > HALF_DEPTH);
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    // Control: write-block steers the write path, flush is a one-cycle partial reset
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wBlock_q <= 1'b0;
            flush_q <= 1'b0;
        end else if (clkEn) begin
            flush_q <= apbWrite && apbReq.pwdata[CTRL_FLUSH];
            if (apbWrite) begin
                wBlock_q <= apbReq.pwdata[CTRL_WBLOCK];
            end
        end
    end

    // Answer is prepared in setup so every bus output stays a flip-flop
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (clkEn) begin
            pready_q <= apbSetup;
            pslverr_q <= apbSetup && !hitAny;
            if (apbSetup && !apbReq.pwrite) begin
                if (hitCtrl) begin
                    prdata_q <= {30'h0, 1'b0, wBlock_q};
                end else if (hitStatus) begin
                    prdata_q <= {24'h0, outValid_q, serialLoad_q, fwftMode_q, flags_q};
                end else if (hitCount) begin
                    prdata_q <= {15'h0, memCount};
                end else if (hitOffsets) begin
                    prdata_q <= {fullOff_q, emptyOff_q};
                end else begin
                    prdata_q <= 32'h00000000;
                end
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign readDataOut = dataOut_q;
    assign readDataOeN = oeN_q;
    assign flags = flags_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    wire quiet = clkEn && fullInitN && softInitN && !flush_q && rereadN && !wBlock_q;

    sequence sFallStart;
        fwftMode_q && !outValid_q && seenEmpty && (memCount == 17'h00000) && wrMem && quiet;
    endsequence
    sequence sFallWait;
        (quiet && readEnN)[*4];
    endsequence

    a_full_reset_clear: assert property (
        (clkEn && !fullInitN) |=> (wrPtr_q == 17'h0 && rdPtr_q == 17'h0 && readDataOut == 9'h000))
        else $error("full reset left pointers or output set");
    a_default_offset_pick: assert property (
        (clkEn && !fullInitN) |=> (emptyOff_q == ($past(offsetAccessN) ? DEF_OFF_HIGH : DEF_OFF_LOW)
                                  && serialLoad_q == $past(offsetAccessN)))
        else $error("default offset or loading method wrong");
    a_soft_keeps_setup: assert property (
        (clkEn && fullInitN && !softInitN) |=> ($stable(fwftMode_q) && $stable(serialLoad_q)
                                              && $stable(emptyOff_q) && wrPtr_q == 17'h0))
        else $error("partial reset disturbed configuration");
    a_reread_pointer: assert property (
        (clkEn && fullInitN && softInitN && !flush_q && !rereadN) |=> (rdPtr_q == 17'h0 && ($stable(wrPtr_q)
                                                                  || $past(wrMem))))
        else $error("reread did not rewind read pointer");
    a_reread_flag: assert property (
        (clkEn && fullInitN && softInitN && !flush_q && !rereadN) |=> (flags.emptyOrValidOut == fwftMode_q))
        else $error("reread did not force the empty or valid flag");
    a_full_write_ignored: assert property (
        (quiet && isFull && !writeEnN && offsetAccessN) |=> (wrPtr_q == $past(wrPtr_q)))
        else $error("write accepted while full");
    a_fall_through_latency: assert property (
        sFallStart ##1 sFallWait |=> ($past(outValid_q) && outValid_q && flags.emptyOrValidOut == 1'b0))
        else $error("first word did not fall through in three edges");
    a_near_full_level: assert property (
        clkEn |=> (flags.nearFullN == !($past(memCount) > (DEPTH - {1'b0, $past(fullOff_q)}))))
        else $error("near-full flag wrong");
    a_near_empty_level: assert property (
        clkEn |=> (flags.nearEmptyN == !($past(memCount) < {1'b0, $past(emptyOff_q)})))
        else $error("near-empty flag wrong");
    a_half_mark_level: assert property (
        clkEn |=> (flags.halfMarkN == !($past(memCount) > HALF_DEPTH)))
        else $error("half mark wrong");
    a_full_flag_mode: assert property (
        clkEn |=> (flags.fullOrSpaceOut == ($past(fwftMode_q) ? $past(isFull) : !$past(isFull))))
        else $error("full or space flag wrong");
endmodule // dual_clock_fifo_9bit
`default_nettype wire

/* hw/dual_clock_fifo_9bit_pkg.sv */
// Constants, field layouts and carrier types for the deep 9-bit FIFO
package dual_clock_fifo_9bit_pkg;
    // ****************************************
    // Storage geometry
    // ****************************************
    localparam int DATA_W = 9;                 // Word width on both buses
    localparam int PTR_W = 17;                 // Address bits plus wrap bit
    localparam int ADDR_W = 16;                // Memory address bits
    localparam int OFF_W = 16;                 // Flag offset width
    localparam logic [PTR_W-1:0] DEPTH = 17'h10000;     // 65,536 words
    localparam logic [PTR_W-1:0] HALF_DEPTH = 17'h08000; // Half of capacity
    // ****************************************
    // Offset defaults and loading order
    // ****************************************
    localparam logic [OFF_W-1:0] DEF_OFF_LOW = 16'h007F;  // 127
    localparam logic [OFF_W-1:0] DEF_OFF_HIGH = 16'h03FF; // 1,023
    localparam int OFF_LO_W = 9;               // Bits moved by the first word of a pair
    localparam logic [1:0] OFF_STEP_LAST = 2'h3; // Empty lo, empty hi, full lo, full hi
    localparam int SHIFT_W = 32;               // Serial chain: empty offset then full offset
    localparam int FALL_DELAY = 2;             // Write pointer stages before the read side
    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam int PADDR_W = 12;
    localparam logic [PADDR_W-1:0] ADDR_CTRL = 12'h000;
    localparam logic [PADDR_W-1:0] ADDR_STATUS = 12'h004;
    localparam logic [PADDR_W-1:0] ADDR_COUNT = 12'h008;
    localparam logic [PADDR_W-1:0] ADDR_OFFSETS = 12'h00C;
    localparam int CTRL_WBLOCK = 0;            // Write-block bit in control
    localparam int CTRL_FLUSH = 1;             // Self-clearing partial reset bit
    localparam int STAT_FALLTHROUGH_MODE = 5;              // Mode bit position in status
    localparam int STAT_SERIAL = 6;            // Loading method bit position
    localparam int STAT_VALID = 7;             // Output register holds a word
    localparam int OFFS_FULL_LSB = 16;         // Full offset field in OFFSETS
    // ****************************************
    // Carrier types
    // ****************************************
    typedef struct packed {
        logic fullOrSpaceOut;                  // Full (low) or space available (low)
        logic emptyOrValidOut;                 // Empty (low) or output valid (low)
        logic nearFullN;
        logic nearEmptyN;
        logic halfMarkN;
    } flags_s;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [PADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;
endpackage

/* tb/stream_agent.sv */
// Writing and reading agent that faces the FIFO data ports
`timescale 1ns/1ps
`default_nettype none
module stream_agent (
    // Clock
    input wire logic clk,
    // Write side
    output logic [dual_clock_fifo_9bit_pkg::DATA_W-1:0] writeDataIn,
    output logic writeEnN,
    // Read side
    output logic readEnN,
    input wire logic [dual_clock_fifo_9bit_pkg::DATA_W-1:0] readDataOut
);
    import dual_clock_fifo_9bit_pkg::*;
    // ****************************************
    // Idle levels and transfer tasks
    // ****************************************
    initial begin
        writeDataIn = '0;
        writeEnN = 1'b1;
        readEnN = 1'b1;
    end
    task automatic push(input logic [DATA_W-1:0] d);
        @(posedge clk);
        writeEnN <= 1'b0;
        writeDataIn <= d;
        @(posedge clk);
        writeEnN <= 1'b1;
        // Released bus shows the inverse, so a stale word cannot pass for fresh data
        writeDataIn <= ~d;
    endtask
    // Back-to-back stream of counting words; overruns the buffer on purpose
    task automatic fill(input int n);
        @(posedge clk);
        writeEnN <= 1'b0;
        repeat (n) begin
            @(posedge clk);
            writeDataIn <= writeDataIn + 9'h001;
        end
        writeEnN <= 1'b1;
    endtask
    // word is on the bus just after the taking edge
    task automatic pop(output logic [DATA_W-1:0] d);
        @(posedge clk);
        readEnN <= 1'b0;
        @(posedge clk);
        readEnN <= 1'b1;
        #1;
        d = readDataOut;
    endtask
endmodule // stream_agent
`default_nettype wire

/* tb/dual_clock_fifo_9bit_test.sv */
// Self-checking bench for the deep 9-bit FIFO
`timescale 1ns/1ps
`default_nettype none
module dual_clock_fifo_9bit_test;
    import dual_clock_fifo_9bit_pkg::*;
    // ****************************************
    // Stimulus, observation and scoring
    // ****************************************
    logic clk_sys = 1'b0, rstn = 1'b0, clkEn = 1'b1, bitloadEnN = 1'b1, modeSelSerialIn = 1'b0;
    logic offsetAccessN = 1'b1, fullInitN = 1'b1, softInitN = 1'b1, rereadN = 1'b1, outputEnableN = 1'b0;
    logic writeEnN, readEnN, readDataOeN, pready, pslverr, err;
    logic [DATA_W-1:0] writeDataIn, readDataOut, rd9;
    logic [31:0] prdata, rd;
    flags_s flags;
    apb_req_s apbReq = '0;
    int n_fail = 0;
    int cmp_count = 0;
    // Offset words in load order: empty lo, empty hi, full lo, full hi
    logic [DATA_W-1:0] offWords [4] = '{9'h005, 9'h000, 9'h07F, 9'h000};
    localparam logic [31:0] SER_VAL = 32'h0010_0003; // Full offset 16, empty offset 3
    dual_clock_fifo_9bit dual_clock_fifo_9bit_inst (.clk_sys, .rstn, .clkEn, .writeDataIn, .writeEnN,
        .bitloadEnN, .modeSelSerialIn, .offsetAccessN, .fullInitN, .softInitN, .rereadN, .readEnN,
        .outputEnableN, .readDataOut, .readDataOeN, .flags, .apbReq, .prdata, .pready, .pslverr);
    stream_agent stream_agent_inst (.clk(clk_sys), .writeDataIn, .writeEnN, .readEnN, .readDataOut);
    // 10 MHz clock
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    // Compare and count; case inequality so unknowns never match
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // APB transfer: request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [PADDR_W-1:0] a, input logic [31:0] wd);
        int n = 0;
        @(posedge clk_sys);
        apbReq <= '{1'b1, 1'b0, wr, a, wd};
        @(posedge clk_sys);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        apbReq <= '0;
        chk("pready", 32'h1, {31'h0, pready});
    endtask
    task automatic rdchk(input logic [PADDR_W-1:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk("apb read", exp, rd);
    endtask
    // Full initialisation; mode and access pins only count while it is low
    task automatic init(input logic mode, input logic acc);
        @(posedge clk_sys);
        fullInitN <= 1'b0;
        modeSelSerialIn <= mode;
        offsetAccessN <= acc;
        @(posedge clk_sys);
        fullInitN <= 1'b1;
        offsetAccessN <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Watchdog sized for the 65,540-word overrun plus margin
    initial begin
        repeat (90000) @(posedge clk_sys);
        n_fail++;
        final_report;
    end
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        init(1'b0, 1'b0);
        chk("flags", 32'h15, {27'h0, flags});
        chk("dout", 32'h0, {23'h0, readDataOut});
        chk("oe", 32'h0, {31'h0, readDataOeN});
        rdchk(ADDR_STATUS, 32'h15);
        rdchk(ADDR_OFFSETS, {DEF_OFF_LOW, DEF_OFF_LOW});
        // Parallel offsets n = 5, m = 127, then one offset read back
        @(posedge clk_sys);
        offsetAccessN <= 1'b0;
        foreach (offWords[i]) begin
            stream_agent_inst.push(offWords[i]);
        end
        stream_agent_inst.pop(rd9);
        chk("offset read", 32'h5, {23'h0, rd9});
        @(posedge clk_sys);
        offsetAccessN <= 1'b1;
        rdchk(ADDR_OFFSETS, 32'h007F_0005);
        // Near-empty threshold sits between 4 and 5 words
        for (logic [8:0] k = 9'h0A0; k < 9'h0A5; k++) begin
            stream_agent_inst.push(k);
            repeat (6) @(posedge clk_sys);
            #1;
            chk("flags", (k == 9'h0A4) ? 32'h1F : 32'h1D, {27'h0, flags});
        end
        for (logic [8:0] k = 9'h0A0; k < 9'h0A2; k++) begin
            stream_agent_inst.pop(rd9);
            chk("dout", {23'h0, k}, {23'h0, rd9});
        end
        // Reread in mid-stream restarts from the first word
        @(posedge clk_sys);
        rereadN <= 1'b0;
        @(posedge clk_sys);
        rereadN <= 1'b1;
        #1;
        chk("reread empty", 32'h0, {31'h0, flags.emptyOrValidOut});
        repeat (6) @(posedge clk_sys);
        for (logic [8:0] k = 9'h0A0; k < 9'h0A5; k++) begin
            stream_agent_inst.pop(rd9);
            chk("dout", {23'h0, k}, {23'h0, rd9});
        end
        // Partial reset keeps programmed offsets
        stream_agent_inst.push(9'h155);
        @(posedge clk_sys);
        softInitN <= 1'b0;
        @(posedge clk_sys);
        softInitN <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        chk("flags", 32'h15, {27'h0, flags});
        rdchk(ADDR_OFFSETS, 32'h007F_0005);
        // Write-block drops writes; a read on an empty buffer leaves the output alone
        apb(1'b1, ADDR_CTRL, 32'h1);
        rdchk(ADDR_CTRL, 32'h1);
        stream_agent_inst.push(9'h0AA);
        stream_agent_inst.pop(rd9);
        chk("empty pop", 32'h0, {23'h0, rd9});
        rdchk(ADDR_COUNT, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h0);
        // Overrun: four extra words must be dropped
        stream_agent_inst.fill(65540);
        repeat (6) @(posedge clk_sys);
        #1;
        chk("flags full", 32'h0A, {27'h0, flags});
        rdchk(ADDR_COUNT, 32'h0001_0000);
        // Fall-through mode, high default, serial loading
        @(posedge clk_sys);
        outputEnableN <= 1'b1;
        init(1'b1, 1'b1);
        chk("oe", 32'h1, {31'h0, readDataOeN});
        rdchk(ADDR_STATUS, 32'h6D);
        rdchk(ADDR_OFFSETS, {DEF_OFF_HIGH, DEF_OFF_HIGH});
        @(posedge clk_sys);
        offsetAccessN <= 1'b0;
        bitloadEnN <= 1'b0;
        modeSelSerialIn <= SER_VAL[0];
        for (int i = 1; i < 32; i++) begin
            @(posedge clk_sys);
            modeSelSerialIn <= SER_VAL[i];
        end
        @(posedge clk_sys);
        offsetAccessN <= 1'b1;
        bitloadEnN <= 1'b1;
        rdchk(ADDR_OFFSETS, SER_VAL);
        stream_agent_inst.push(9'h1A5);
        repeat (4) @(posedge clk_sys);
        #1;
        chk("fall dout", 32'h1A5, {23'h0, readDataOut});
        chk("fall flags", 32'h05, {27'h0, flags});
        // Flush through the control register, then an unmapped address
        apb(1'b1, ADDR_CTRL, 32'h2);
        repeat (3) @(posedge clk_sys);
        #1;
        chk("flush flags", 32'h0D, {27'h0, flags});
        apb(1'b0, 12'h010, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        chk("unmapped", 32'h0, rd);
        final_report;
    end
endmodule // dual_clock_fifo_9bit_test
`default_nettype wire
